/* supv_pkg.sv */
// Purpose: Shared constants and types for the reset supervisor.
// Assumes: 50 MHz system clock, 32-bit AXI4-Lite register bus.
// Notes: Times are kept in ms; cycle counts are derived from the clock rate.
package supv_pkg;
  localparam int CLK_HZ = 50_000_000;
  localparam int CYC_PER_MS = CLK_HZ / 1000;
  // Reset hold: nominal and longest time
  localparam int HOLD_MS = 160;
  localparam int HOLD_MAX_MS = 180;
  localparam int HOLD_CYC = HOLD_MS * CYC_PER_MS;
  localparam int HOLD_MAX_CYC = HOLD_MAX_MS * CYC_PER_MS;
  // Pushbutton debounce time
  localparam int DB_MS = 160;
  localparam int DB_CYC = DB_MS * CYC_PER_MS;
  // Oscillator halt detect delay
  localparam int HALT_MS = 20;
  localparam int HALT_CYC = HALT_MS * CYC_PER_MS;

  localparam int ADDR_W = 5;
  localparam logic [4:0] OFF_CTRL = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_MASK = 5'h08;
  localparam logic [4:0] OFF_STATE = 5'h0C;

  // Control register fields
  localparam int CTRL_OSC_EN = 0;
  localparam logic CTRL_OSC_EN_RST = 1'h1;

  // Status and mask layout
  localparam int EV_W = 4;
  localparam int EV_HALT = 0;
  localparam int EV_FAIL = 1;
  localparam int EV_BUTTON = 2;
  localparam int EV_RELEASE = 3;
  localparam logic [EV_W-1:0] MASK_RST = 4'h0;

  // Live state register fields
  localparam int SV_RST_ACTIVE = 0;
  localparam int SV_SUPPLY_LOW = 1;
  localparam int SV_OSC_OK = 2;
  localparam int SV_ACCESS = 3;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    SUP_FAIL = 2'h0,
    SUP_HOLD = 2'h1,
    SUP_RUN = 2'h3
  } sup_state_t;
endpackage

/* sync2.sv */
// Purpose: Two-stage synchroniser for asynchronous levels.
// Assumes: Inputs are slow levels; one bit never relates to another.
// Notes: No reset, so the output always follows the pin after two edges.
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1
) (
  input wire logic clk, // System clock
  input wire logic [W-1:0] d, // Asynchronous levels
  output logic [W-1:0] q // Synchronised levels
);
  logic [W-1:0] meta_q;
  always_ff @(posedge clk) begin
    meta_q <= d;
    q <= meta_q;
  end
endmodule // sync2
`default_nettype wire

/* reset_supervisor.sv */
// Purpose: Supply and pushbutton reset supervisor with AXI4-Lite registers.
// Assumes: power_fail high while the supply is below threshold.
// Notes: The reset pin is open drain; only a low is ever driven.
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor import supv_pkg::*; #(
  parameter int HOLD_CYCLES = HOLD_CYC,
  parameter int DB_CYCLES = DB_CYC,
  parameter int HALT_CYCLES = HALT_CYC
) (
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic power_fail, // Comparator: supply below threshold
  input wire logic osc_running, // Oscillator running indication
  input wire logic rst_pin_in, // Reset pin level
  output logic rst_pin_out, // Reset pin drive value, always low
  output logic rst_pin_oe, // Reset pin driven low
  output logic serial_accept, // Serial inputs recognised
  output logic access_ok, // Clock registers accessible
  output logic oscillator_halt_flag, // Oscillator was halted
  output logic irq, // Level interrupt
  input wire logic [ADDR_W-1:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [ADDR_W-1:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready // Read data ready
);
  localparam int CNT_W = $clog2(HOLD_CYCLES + DB_CYCLES + HALT_CYCLES) + 1;
  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CYCLES - 1);
  localparam logic [CNT_W-1:0] DB_LAST = CNT_W'(DB_CYCLES - 1);
  localparam logic [CNT_W-1:0] HALT_LAST = CNT_W'(HALT_CYCLES - 1);

  logic pf_s, pin_s, osc_s, osc_ok, btn_low, press_ev, halt_ev;
  sup_state_t state_q, state_d;
  logic [CNT_W-1:0] hold_cnt_q, hold_cnt_d, db_cnt_q, db_cnt_d;
  logic [CNT_W-1:0] halt_cnt_q, halt_cnt_d;
  logic oe_q, oe_d, acc_q, acc_d, irq_q, irq_d;
  logic osc_en_q, osc_en_d;
  logic [EV_W-1:0] status_q, status_d, mask_q, mask_d, ev;
  logic awready_q, awready_d, wready_q, wready_d, bvalid_q, bvalid_d;
  logic arready_q, arready_d, rvalid_q, rvalid_d;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic wr_go;

  sync2 #(.W(3)) u_sync (
    .clk(clk),
    .d({power_fail, rst_pin_in, osc_running}),
    .q({pf_s, pin_s, osc_s})
  );

  assign osc_ok = osc_en_q && osc_s;
  // Our own drive pulls the pin low, so the button is only seen in run
  assign btn_low = !pin_s && (state_q == SUP_RUN);
  assign press_ev = btn_low && (db_cnt_q == DB_LAST);
  assign halt_ev = !osc_ok && (halt_cnt_q == HALT_LAST);

  always_comb begin
    state_d = state_q;
    hold_cnt_d = hold_cnt_q;
    db_cnt_d = btn_low ? db_cnt_q + CNT_W'(1) : '0;
    if (press_ev) begin
      db_cnt_d = '0;
    end
    halt_cnt_d = osc_ok ? '0 : halt_cnt_q;
    if (!osc_ok && halt_cnt_q != HALT_LAST) begin
      halt_cnt_d = halt_cnt_q + CNT_W'(1);
    end
    unique case (state_q)
      SUP_FAIL: begin
        hold_cnt_d = '0;
        if (!pf_s) begin
          state_d = SUP_HOLD;
        end
      end
      SUP_HOLD: begin
        if (osc_ok) begin
          hold_cnt_d = hold_cnt_q + CNT_W'(1);
        end
        if (osc_ok && hold_cnt_q == HOLD_LAST) begin
          state_d = SUP_RUN;
          hold_cnt_d = '0;
        end
      end
      SUP_RUN: begin
        if (press_ev) begin
          state_d = SUP_HOLD;
          hold_cnt_d = '0;
        end
      end
    endcase
    if (pf_s) begin
      state_d = SUP_FAIL;
      hold_cnt_d = '0;
    end
    oe_d = (state_d != SUP_RUN);
    acc_d = (state_d == SUP_RUN);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= SUP_FAIL;
      hold_cnt_q <= '0;
      db_cnt_q <= '0;
      halt_cnt_q <= '0;
      oe_q <= 1'h1;
      acc_q <= 1'h0;
    end else begin
      state_q <= state_d;
      hold_cnt_q <= hold_cnt_d;
      db_cnt_q <= db_cnt_d;
      halt_cnt_q <= halt_cnt_d;
      oe_q <= oe_d;
      acc_q <= acc_d;
    end
  end

  // Register slave: address and data may arrive in either order
  assign wr_go = !awready_q && !wready_q && !bvalid_q;
  assign ev[EV_HALT] = halt_ev;
  assign ev[EV_FAIL] = pf_s && (state_q != SUP_FAIL);
  assign ev[EV_BUTTON] = press_ev;
  assign ev[EV_RELEASE] = (state_q == SUP_HOLD) && (state_d == SUP_RUN);

  always_comb begin
    awready_d = awready_q;
    wready_d = wready_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    osc_en_d = osc_en_q;
    mask_d = mask_q;
    status_d = status_q;
    if (s_axi_awvalid && awready_q) begin
      awready_d = 1'h0;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      wready_d = 1'h0;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (wr_go) begin
      bvalid_d = 1'h1;
      bresp_d = RESP_OKAY;
      unique case (awaddr_q)
        OFF_CTRL: begin
          if (wstrb_q[0]) begin
            osc_en_d = wdata_q[CTRL_OSC_EN];
          end
        end
        OFF_STATUS: begin
          if (wstrb_q[0]) begin
            status_d = status_q & ~wdata_q[EV_W-1:0];
          end
        end
        OFF_MASK: begin
          if (wstrb_q[0]) begin
            mask_d = wdata_q[EV_W-1:0];
          end
        end
        OFF_STATE: begin
        end
        default: bresp_d = RESP_SLVERR;
      endcase
    end
    if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'h0;
      awready_d = 1'h1;
      wready_d = 1'h1;
    end
    // An event in the clearing cycle still sets its bit
    status_d = status_d | ev;
    irq_d = |(status_d & mask_d);
  end

  always_comb begin
    arready_d = arready_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    if (s_axi_arvalid && arready_q) begin
      arready_d = 1'h0;
      rvalid_d = 1'h1;
      rresp_d = RESP_OKAY;
      rdata_d = '0;
      unique case (s_axi_araddr)
        OFF_CTRL: rdata_d[CTRL_OSC_EN] = osc_en_q;
        OFF_STATUS: rdata_d[EV_W-1:0] = status_q;
        OFF_MASK: rdata_d[EV_W-1:0] = mask_q;
        OFF_STATE: begin
          rdata_d[SV_RST_ACTIVE] = oe_q;
          rdata_d[SV_SUPPLY_LOW] = pf_s;
          rdata_d[SV_OSC_OK] = osc_ok;
          rdata_d[SV_ACCESS] = acc_q;
        end
        default: rresp_d = RESP_SLVERR;
      endcase
    end
    if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'h0;
      arready_d = 1'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      awready_q <= 1'h1;
      wready_q <= 1'h1;
      bvalid_q <= 1'h0;
      bresp_q <= RESP_OKAY;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      arready_q <= 1'h1;
      rvalid_q <= 1'h0;
      rdata_q <= '0;
      rresp_q <= RESP_OKAY;
      osc_en_q <= CTRL_OSC_EN_RST;
      mask_q <= MASK_RST;
      status_q <= '0;
      irq_q <= 1'h0;
    end else begin
      awready_q <= awready_d;
      wready_q <= wready_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      arready_q <= arready_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
      osc_en_q <= osc_en_d;
      mask_q <= mask_d;
      status_q <= status_d;
      irq_q <= irq_d;
    end
  end

  // Open drain: only ever drives low, released means enable off
  assign rst_pin_out = 1'h0;
  assign rst_pin_oe = oe_q;
  assign serial_accept = !oe_q;
  assign access_ok = acc_q;
  assign oscillator_halt_flag = status_q[EV_HALT];
  assign irq = irq_q;
  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  fail_drives_a: assert property (pf_s |=> rst_pin_oe)
    else $error("reset not driven on supply failure");
  hold_length_a: assert property ($fell(oe_q) |->
      $past(hold_cnt_q) == HOLD_LAST && $past(state_q) == SUP_HOLD)
    else $error("reset released before full hold");
  serial_gate_a: assert property (serial_accept |->
      !rst_pin_oe && state_q == SUP_RUN)
    else $error("serial inputs accepted during hold");
  osc_stall_a: assert property (
      (state_q == SUP_HOLD && !osc_ok && !pf_s) |=> $stable(hold_cnt_q))
    else $error("hold advanced without oscillator");
  button_drive_a: assert property (press_ev && !pf_s |=>
      rst_pin_oe && state_q == SUP_HOLD && hold_cnt_q == '0)
    else $error("validated press did not drive reset");
  halt_flag_a: assert property (halt_ev |=> oscillator_halt_flag)
    else $error("halt flag not set after delay");
  access_block_a: assert property (pf_s |=> !access_ok [*2])
    else $error("access allowed while supply low");
  debounce_len_a: assert property (press_ev |->
      db_cnt_q == DB_LAST && !pin_s && $past(!pin_s))
    else $error("press accepted without debounce");
  sync_path_a: assert property (pf_s == $past(power_fail, 2))
    else $error("comparator level not two-stage synchronised");
  irq_level_a: assert property (irq == $past(|(status_d & mask_d)))
    else $error("interrupt does not follow masked status");

  fail_recover_c: cover property ($rose(pf_s) ##[1:20] $fell(pf_s));
  release_c: cover property ($fell(rst_pin_oe));
  press_c: cover property (press_ev);
  halt_c: cover property ($rose(oscillator_halt_flag));
endmodule // reset_supervisor
`default_nettype wire

/* button_model.sv */
// Purpose: Pushbutton and pull-up on the shared open-drain reset pin.
// Assumes: Contact closed or the device drive pulls the pin low; otherwise the pull-up wins.
// Notes: Bounce opens and closes the contact every 3 cycles.
`timescale 1ns/1ps
`default_nettype none
module button_model (
  input wire logic clk, // System clock
  input wire logic press, // Button held closed
  input wire logic bounce, // Contact chatters
  input wire logic rst_pin_out, // Device drive value
  input wire logic rst_pin_oe, // Device drives the pin
  output logic pin // Resolved pin level
);
  logic [2:0] ph_q;
  logic contact;
  // Phase restarts whenever chatter is off, so it is never left unknown
  always_ff @(posedge clk) begin
    ph_q <= (!bounce || ph_q == 3'h5) ? 3'h0 : ph_q + 3'h1;
  end
  assign contact = press | (bounce & (ph_q < 3'h3));
  assign pin = (rst_pin_oe ? rst_pin_out : 1'b1) & ~contact;
endmodule // button_model
`default_nettype wire

/* reset_supervisor_tb.sv */
// Purpose: Self-checking bench for the reset supervisor.
// Assumes: Short hold, debounce and halt counts for a quick run.
// Notes: Pin level comes from the button model and the pull-up.
`timescale 1ns/1ps
`default_nettype none
module reset_supervisor_tb;
  import supv_pkg::*;
  localparam int HC = 20;
  localparam int DC = 8;
  localparam int TC = 10;
  logic clk, rst_n, power_fail, osc_running, rst_pin_in, rst_pin_out;
  logic rst_pin_oe, serial_accept, access_ok, oscillator_halt_flag, irq;
  logic [4:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, press, bounce;
  logic [31:0] d;
  int n_mismatch = 0;
  int cmp_count = 0;
  int n;
  reset_supervisor #(.HOLD_CYCLES(HC), .DB_CYCLES(DC), .HALT_CYCLES(TC))
    i_reset_supervisor (.clk(clk), .rst_n(rst_n), .power_fail(power_fail),
    .osc_running(osc_running), .rst_pin_in(rst_pin_in),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe),
    .serial_accept(serial_accept), .access_ok(access_ok),
    .oscillator_halt_flag(oscillator_halt_flag), .irq(irq),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  button_model i_button_model (.clk(clk), .press(press), .bounce(bounce),
    .rst_pin_out(rst_pin_out), .rst_pin_oe(rst_pin_oe), .pin(rst_pin_in));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic rng(input int v, input int lo, input int hi, input string m);
    chk({31'h0, (v >= lo && v <= hi)}, 32'h1, m);
  endtask
  task automatic axw(input logic [4:0] a, input logic [31:0] dv);
    bit aw, w;
    aw = 0;
    w = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(posedge clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(aw && w));
    s_axi_bready <= 1'b1;
    do @(posedge clk); while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axr(input logic [4:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Counts cycles of driven reset; serial and access must stay off meanwhile
  task automatic hold_len(input int lo, input int hi);
    int bad;
    n = 0;
    bad = 0;
    while (rst_pin_oe === 1'b1 && n < 500) begin
      if (serial_accept !== 1'b0 || access_ok !== 1'b0) bad++;
      @(posedge clk);
      n++;
    end
    rng(n, lo, hi, "reset hold length");
    chk(bad, 0, "inputs recognised during hold");
    @(posedge clk);
    chk({serial_accept, access_ok}, 2'h3, "not accepting after release");
  endtask
  task automatic t_regs();
    axr(OFF_CTRL); chk(d, 32'h1, "ctrl reset value");
    axr(OFF_MASK); chk(d, 32'h0, "mask reset value");
    axw(OFF_STATE, 32'h0); chk(r, RESP_OKAY, "state write resp");
    axr(OFF_STATE); chk(d, 32'hC, "state after release");
    axw(5'h14, 32'hF); chk(r, RESP_SLVERR, "unmapped write");
    axr(5'h10); chk(r, RESP_SLVERR, "unmapped read resp");
    chk(d, 32'h0, "unmapped read data");
    axw(OFF_MASK, 32'hF); axr(OFF_MASK); chk(d, 32'hF, "mask rw");
    axw(OFF_MASK, 32'h0);
  endtask
  task automatic t_fail();
    power_fail <= 1'b1;
    repeat (2) @(posedge clk);
    chk(rst_pin_oe, 1'b0, "pin driven before sync");
    repeat (3) @(posedge clk);
    chk({rst_pin_oe, access_ok, serial_accept}, 3'h4, "fail response");
    repeat (30) @(posedge clk);
    chk({rst_pin_oe, rst_pin_in}, 2'h2, "pin not low while supply low");
    power_fail <= 1'b0;
    hold_len(HC, HC + 8);
    axr(OFF_STATUS); chk(d & 32'hA, 32'hA, "fail and release events");
    axw(OFF_STATUS, 32'hF); axr(OFF_STATUS); chk(d, 32'h0, "w1c clear");
  endtask
  task automatic t_osc();
    osc_running <= 1'b0;
    power_fail <= 1'b1;
    repeat (8) @(posedge clk);
    power_fail <= 1'b0;
    repeat (HC + 20) @(posedge clk);
    chk(rst_pin_oe, 1'b1, "released with oscillator stopped");
    chk(oscillator_halt_flag, 1'b1, "halt flag not set");
    osc_running <= 1'b1;
    hold_len(HC, HC + 8);
    axw(OFF_STATUS, 32'hF);
    @(posedge clk);
    chk(oscillator_halt_flag, 1'b0, "halt flag not cleared");
  endtask
  task automatic t_halt();
    axw(OFF_CTRL, 32'h0);
    n = 0;
    while (oscillator_halt_flag !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    rng(n, TC - 2, TC + 6, "halt detect delay");
    chk(irq, 1'b0, "irq while masked");
    axw(OFF_CTRL, 32'h1);
    axw(OFF_STATUS, 32'hF);
  endtask
  task automatic t_button();
    int bad;
    bad = 0;
    axw(OFF_MASK, 32'h4);
    bounce <= 1'b1;
    repeat (40) begin
      @(posedge clk);
      if (rst_pin_oe !== 1'b0) bad++;
    end
    bounce <= 1'b0;
    chk(bad, 0, "bounce caused reset");
    chk(irq, 1'b0, "irq before press");
    press <= 1'b1;
    n = 0;
    while (rst_pin_oe !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    rng(n, DC, DC + 6, "debounce length");
    repeat (3) @(posedge clk);
    chk(irq, 1'b1, "button irq");
    press <= 1'b0;
    // Four cycles of the hold have already passed since the press took
    hold_len(HC - 4, HC);
    axw(OFF_MASK, 32'h0); repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq not masked");
    axw(OFF_MASK, 32'h4); repeat (2) @(posedge clk);
    chk(irq, 1'b1, "irq not unmasked");
    axw(OFF_STATUS, 32'h4); repeat (2) @(posedge clk);
    chk(irq, 1'b0, "irq not cleared");
  endtask
  task automatic test_done();
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
  initial begin
    rst_n = 1'b0; power_fail = 1'b0; osc_running = 1'b1;
    press = 1'b0; bounce = 1'b0; s_axi_wstrb = 4'hF;
    s_axi_awaddr = 5'h00; s_axi_araddr = 5'h00; s_axi_wdata = 32'h0;
    s_axi_awvalid = 1'b0; s_axi_wvalid = 1'b0; s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0; s_axi_rready = 1'b0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    hold_len(HC, HC + 6);
    t_regs();
    t_fail();
    t_osc();
    t_halt();
    t_button();
    test_done();
  end
endmodule // reset_supervisor_tb
`default_nettype wire
